// [logic/fcsd_pkg.sv]
// Shared constants and carriers of the flash command sequencer.
// Assumes a x16 flash with word addressing driven by this host controller.
package fcsd_pkg;
   localparam int ADDR_W = 26;
   localparam int DATA_W = 16;
   localparam logic [ADDR_W-1:0] LOC_UNLOCK1 = 26'h0000555;
   localparam logic [ADDR_W-1:0] LOC_UNLOCK2 = 26'h00002AA;
   localparam logic [ADDR_W-1:0] LOC_QUERY = 26'h0000055;
   localparam logic [ADDR_W-1:0] LOC_ANY = 26'h0000000;
   localparam logic [DATA_W-1:0] CODE_UNLOCK1 = 16'h00AA;
   localparam logic [DATA_W-1:0] CODE_UNLOCK2 = 16'h0055;
   localparam logic [DATA_W-1:0] CODE_RESET = 16'h00F0;
   localparam logic [DATA_W-1:0] CODE_STAT_RD = 16'h0070;
   localparam logic [DATA_W-1:0] CODE_STAT_CLR = 16'h0071;
   localparam logic [DATA_W-1:0] CODE_PROG = 16'h00A0;
   localparam logic [DATA_W-1:0] CODE_BUF_LOAD = 16'h0025;
   localparam logic [DATA_W-1:0] CODE_BUF_CONF = 16'h0029;
   localparam logic [DATA_W-1:0] CODE_ERASE = 16'h0080;
   localparam logic [DATA_W-1:0] CODE_CHIP = 16'h0010;
   localparam logic [DATA_W-1:0] CODE_SECTOR = 16'h0030;
   localparam logic [DATA_W-1:0] CODE_SUSP = 16'h00B0;
   localparam logic [DATA_W-1:0] CODE_PSUSP = 16'h0051;
   localparam logic [DATA_W-1:0] CODE_RESUME = 16'h0030;
   localparam logic [DATA_W-1:0] CODE_PRESUME = 16'h0050;
   localparam logic [DATA_W-1:0] CODE_ID = 16'h0090;
   localparam logic [DATA_W-1:0] CODE_QUERY = 16'h0098;
   localparam logic [DATA_W-1:0] CODE_SECURE = 16'h0088;
   localparam logic [DATA_W-1:0] CODE_LOCK = 16'h0040;
   localparam logic [DATA_W-1:0] CODE_EXIT = 16'h0000;
   // Bus cycle timing in ns and in 50 ns clock cycles, rounded up.
   localparam int CLK_NS = 50;
   localparam int T_WE_NS = 100;
   localparam int T_RD_NS = 100;
   localparam logic [3:0] WE_CYC = 4'((T_WE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] RD_CYC = 4'((T_RD_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] GAP_CYC = 4'h1;

   typedef enum logic [3:0]
   {
      FCSD_OP_READ = 4'h0, FCSD_OP_RESET = 4'h1, FCSD_OP_STAT_RD = 4'h2,
      FCSD_OP_STAT_CLR = 4'h3, FCSD_OP_PROG = 4'h4, FCSD_OP_BUF = 4'h5,
      FCSD_OP_BUF_ABORT = 4'h6, FCSD_OP_CHIP_ERASE = 4'h7,
      FCSD_OP_SECT_ERASE = 4'h8, FCSD_OP_SUSPEND = 4'h9,
      FCSD_OP_RESUME = 4'hA, FCSD_OP_ID = 4'hB, FCSD_OP_QUERY = 4'hC,
      FCSD_OP_SECURE = 4'hD, FCSD_OP_SECURE_EXIT = 4'hE,
      FCSD_OP_LOCK = 4'hF
   } fcsd_op_t;

   typedef struct packed {
      fcsd_op_t op;
      logic enhanced;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic [8:0] count;
   } fcsd_req_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcsd_cyc_t;

   typedef struct packed {
      logic ce_n;
      logic we_n;
      logic oe_n;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_out;
      logic dq_oe;
   } fcsd_pins_t;
endpackage

// [logic/fcsd_bus_cycle.sv]
// One asynchronous flash bus cycle, write or read, timed in clock cycles.
// Assumes the flash answers a read within the read hold time.
`timescale 1ns/1ns
module fcsd_bus_cycle
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic start,
   input wire logic is_read,
   input wire fcsd_pkg::fcsd_cyc_t cyc,
   input wire logic [fcsd_pkg::DATA_W-1:0] dq_in,
   output fcsd_pkg::fcsd_pins_t pins,
   output logic busy,
   output logic done,
   output logic [fcsd_pkg::DATA_W-1:0] rd_data
);
   import fcsd_pkg::*;

   typedef enum logic [2:0]
   {
      FCSD_BC_IDLE = 3'b001, FCSD_BC_ACT = 3'b010, FCSD_BC_GAP = 3'b100
   } fcsd_bc_state_t;

   typedef struct packed {
      fcsd_bc_state_t st;
      logic [3:0] cnt;
      logic rd;
      logic done;
      fcsd_pins_t pins;
      logic [DATA_W-1:0] rd_data;
   } fcsd_bc_t;

   fcsd_bc_t s;
   fcsd_bc_t next_s;

   always_comb
   begin
      next_s = s;
      next_s.done = 1'b0;
      case (s.st)
         FCSD_BC_IDLE:
         begin
            if (start)
            begin
               next_s.st = FCSD_BC_ACT;
               next_s.rd = is_read;
               next_s.cnt = is_read ? RD_CYC : WE_CYC;
               next_s.pins.ce_n = 1'b0;
               next_s.pins.we_n = is_read;
               next_s.pins.oe_n = !is_read;
               next_s.pins.addr = cyc.addr;
               next_s.pins.dq_out = cyc.data;
               next_s.pins.dq_oe = !is_read;
            end
         end
         FCSD_BC_ACT:
         begin
            if (s.cnt == 4'h1)
            begin
               next_s.st = FCSD_BC_GAP;
               next_s.cnt = GAP_CYC;
               if (s.rd)
               begin
                  next_s.rd_data = dq_in;
               end
               // Data stays driven for one cycle after we_n rises for hold.
               next_s.pins.ce_n = 1'b1;
               next_s.pins.we_n = 1'b1;
               next_s.pins.oe_n = 1'b1;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         FCSD_BC_GAP:
         begin
            next_s.pins.dq_oe = 1'b0;
            if (s.cnt == 4'h1)
            begin
               next_s.st = FCSD_BC_IDLE;
               next_s.done = 1'b1;
            end
            else
            begin
               next_s.cnt = s.cnt - 4'h1;
            end
         end
         default:
         begin
            next_s.st = FCSD_BC_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '{st: FCSD_BC_IDLE, cnt: 4'h0, rd: 1'b0, done: 1'b0,
                pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                        addr: '0, dq_out: '0, dq_oe: 1'b0},
                rd_data: '0};
      end
      else if (clk_en)
      begin
         s <= next_s;
      end
   end

   assign pins = s.pins;
   assign busy = (s.st != FCSD_BC_IDLE);
   assign done = s.done;
   assign rd_data = s.rd_data;

   a_strobe_exclusive: assert property (@(posedge mclk) disable iff (!nrst)
      !(!s.pins.we_n && !s.pins.oe_n))
      else $error("write and read strobes low together");
   a_write_width: assert property (@(posedge mclk) disable iff (!nrst)
      $fell(s.pins.we_n) && clk_en [*1] |=> !s.pins.we_n)
      else $error("write strobe shorter than two cycles");
endmodule

// [logic/fcsd_host.sv]
// Host controller that turns flash command requests into bus cycles.
// Assumes one request at a time; req_ready is high while a new one is taken.
// Notes on behaviour
// - Array read is one bus read at the location, no command first.
// - Writing F0 anywhere returns the flash to array read.
// - Status read: write 70 at 555, then read any location.
// - Writing 71 at 555 clears the status flags.
// - Word program: AA/555, 55/2AA, A0/555, then data at target.
// - Buffer load: unlock, 25 at sector, count minus one, then each slot's word.
// - After the buffer load, 29 at the sector starts programming.
// - Abort recovery: AA/555, 55/2AA, F0/555.
// - Chip erase: AA, 55, 80, AA, 55, then 10 at 555.
// - Sector erase: same five writes, then 30 at the sector.
// - 30 anywhere resumes; 50 resumes programming, enhanced form.
// - Identification entry: AA, 55, then 90 at 555 in the sector.
// - 98 at 55 in a sector enters the query space.
// - In identification or query space each read returns table words.
// - Secure region entry: AA, 55, 88 at 555.
// - Secure exit: AA, 55, 90 at 555, then 0 anywhere.
// - Lock register entry: AA, 55, then 40 at 555.
`timescale 1ns/1ns
module fcsd_host
#(
   parameter int MAX_WORDS = 256
)
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic clk_en,
   input wire logic req_valid,
   output logic req_ready,
   input wire fcsd_pkg::fcsd_req_t req,
   output logic buf_rd,
   output logic [8:0] buf_idx,
   input wire logic [fcsd_pkg::DATA_W-1:0] buf_data,
   output logic resp_valid,
   output logic [fcsd_pkg::DATA_W-1:0] resp_data,
   output logic in_secure,
   output logic in_table,
   output logic flash_ce_n,
   output logic flash_we_n,
   output logic flash_oe_n,
   output logic [fcsd_pkg::ADDR_W-1:0] flash_addr,
   output logic [fcsd_pkg::DATA_W-1:0] flash_dq_out,
   output logic flash_dq_oe,
   input wire logic [fcsd_pkg::DATA_W-1:0] flash_dq_in
);
   import fcsd_pkg::*;

   typedef enum logic [2:0]
   {
      FCSD_IDLE = 3'b001, FCSD_ISSUE = 3'b010, FCSD_WAIT = 3'b100
   } fcsd_state_t;

   typedef struct packed {
      fcsd_state_t st;
      fcsd_req_t r;
      logic [3:0] step;
      logic [8:0] slot;
      logic secure;
      logic table_sp;
      logic resp_valid;
      logic [DATA_W-1:0] resp_data;
   } fcsd_host_t;

   fcsd_host_t s;
   fcsd_host_t next_s;
   fcsd_cyc_t cyc;
   logic cyc_read;
   logic cyc_last;
   logic bc_start;
   logic bc_done;
   logic bc_busy;
   logic [DATA_W-1:0] bc_data;
   fcsd_pins_t pins;

   function automatic fcsd_cyc_t wr(input logic [ADDR_W-1:0] a,
                                    input logic [DATA_W-1:0] d);
      fcsd_cyc_t c;
      c.addr = a;
      c.data = d;
      return c;
   endfunction

   // Unlock pair at steps 0 and 1 used by most sequences.
   function automatic fcsd_cyc_t unlock(input logic [3:0] k);
      return (k == 4'h0) ? wr(LOC_UNLOCK1, CODE_UNLOCK1)
                         : wr(LOC_UNLOCK2, CODE_UNLOCK2);
   endfunction

   // Sector base with the low word bits replaced by an offset.
   function automatic logic [ADDR_W-1:0] in_sector(
      input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      return {a[ADDR_W-1:16], off[15:0]};
   endfunction

   // Cycle table: address, data, whether a read, whether the last one.
   always_comb
   begin
      cyc = wr(s.r.addr, s.r.data);
      cyc_read = 1'b0;
      cyc_last = 1'b1;
      buf_rd = 1'b0;
      buf_idx = s.slot;
      case (s.r.op)
         FCSD_OP_READ:
         begin
            cyc_read = 1'b1;
         end
         FCSD_OP_RESET:
         begin
            cyc = wr(LOC_ANY, CODE_RESET);
         end
         FCSD_OP_STAT_RD:
         begin
            cyc_last = (s.step == 4'h1);
            cyc_read = (s.step == 4'h1);
            if (s.step == 4'h0)
            begin
               cyc = wr(LOC_UNLOCK1, CODE_STAT_RD);
            end
         end
         FCSD_OP_STAT_CLR:
         begin
            cyc = wr(LOC_UNLOCK1, CODE_STAT_CLR);
         end
         FCSD_OP_PROG:
         begin
            cyc_last = (s.step == 4'h3);
            if (s.step < 4'h2)
            begin
               cyc = unlock(s.step);
            end
            else if (s.step == 4'h2)
            begin
               cyc = wr(LOC_UNLOCK1, CODE_PROG);
            end
         end
         FCSD_OP_BUF:
         begin
            cyc_last = 1'b0;
            if (s.step < 4'h2)
            begin
               cyc = unlock(s.step);
            end
            else if (s.step == 4'h2)
            begin
               cyc = wr(s.r.addr, CODE_BUF_LOAD);
            end
            else if (s.step == 4'h3)
            begin
               cyc = wr(s.r.addr, DATA_W'(s.r.count - 9'h001));
            end
            else if (s.step == 4'h4)
            begin
               buf_rd = 1'b1;
               cyc = wr(s.r.addr + ADDR_W'(s.slot), buf_data);
            end
            else
            begin
               cyc = wr(s.r.addr, CODE_BUF_CONF);
               cyc_last = 1'b1;
            end
         end
         FCSD_OP_BUF_ABORT:
         begin
            cyc_last = (s.step == 4'h2);
            cyc = (s.step < 4'h2) ? unlock(s.step)
                                  : wr(LOC_UNLOCK1, CODE_RESET);
         end
         FCSD_OP_CHIP_ERASE, FCSD_OP_SECT_ERASE:
         begin
            cyc_last = (s.step == 4'h5);
            if (s.step == 4'h2)
            begin
               cyc = wr(LOC_UNLOCK1, CODE_ERASE);
            end
            else if (s.step == 4'h5)
            begin
               cyc = (s.r.op == FCSD_OP_CHIP_ERASE)
                  ? wr(LOC_UNLOCK1, CODE_CHIP)
                  : wr(s.r.addr, CODE_SECTOR);
            end
            else
            begin
               cyc = unlock((s.step > 4'h2) ? s.step - 4'h3 : s.step);
            end
         end
         FCSD_OP_SUSPEND:
         begin
            cyc = wr(LOC_ANY, s.r.enhanced ? CODE_PSUSP : CODE_SUSP);
         end
         FCSD_OP_RESUME:
         begin
            cyc = wr(LOC_ANY, s.r.enhanced ? CODE_PRESUME : CODE_RESUME);
         end
         FCSD_OP_ID, FCSD_OP_SECURE, FCSD_OP_LOCK:
         begin
            cyc_last = (s.step == 4'h2);
            if (s.step < 4'h2)
            begin
               cyc = unlock(s.step);
            end
            else if (s.r.op == FCSD_OP_ID)
            begin
               cyc = wr(in_sector(s.r.addr, LOC_UNLOCK1), CODE_ID);
            end
            else if (s.r.op == FCSD_OP_SECURE)
            begin
               cyc = wr(LOC_UNLOCK1, CODE_SECURE);
            end
            else
            begin
               cyc = wr(LOC_UNLOCK1, CODE_LOCK);
            end
         end
         FCSD_OP_QUERY:
         begin
            cyc = wr(in_sector(s.r.addr, LOC_QUERY), CODE_QUERY);
         end
         FCSD_OP_SECURE_EXIT:
         begin
            cyc_last = (s.step == 4'h3);
            if (s.step < 4'h2)
            begin
               cyc = unlock(s.step);
            end
            else if (s.step == 4'h2)
            begin
               cyc = wr(LOC_UNLOCK1, CODE_ID);
            end
            else
            begin
               cyc = wr(LOC_ANY, CODE_EXIT);
            end
         end
         default:
         begin
            cyc_read = 1'b1;
         end
      endcase
   end

   assign bc_start = (s.st == FCSD_ISSUE);

   always_comb
   begin
      next_s = s;
      next_s.resp_valid = 1'b0;
      case (s.st)
         FCSD_IDLE:
         begin
            if (req_valid)
            begin
               next_s.r = req;
               next_s.step = 4'h0;
               next_s.slot = 9'h000;
               next_s.st = FCSD_ISSUE;
            end
         end
         FCSD_ISSUE:
         begin
            next_s.st = FCSD_WAIT;
         end
         FCSD_WAIT:
         begin
            if (bc_done)
            begin
               next_s.st = FCSD_ISSUE;
               if (s.r.op == FCSD_OP_BUF && s.step == 4'h4 &&
                   s.slot + 9'h001 < s.r.count)
               begin
                  next_s.slot = s.slot + 9'h001;
               end
               else
               begin
                  next_s.step = s.step + 4'h1;
               end
               if (cyc_last)
               begin
                  next_s.st = FCSD_IDLE;
                  next_s.resp_valid = 1'b1;
                  next_s.resp_data = cyc_read ? bc_data : '0;
                  // Mode tracking follows reset, secure entry and exit, ID and query; a buffer abort leaves it as it was.
                  case (s.r.op)
                     FCSD_OP_RESET:
                     begin
                        next_s.secure = 1'b0;
                        next_s.table_sp = 1'b0;
                     end
                     FCSD_OP_SECURE_EXIT:
                     begin
                        next_s.secure = 1'b0;
                     end
                     FCSD_OP_SECURE:
                     begin
                        next_s.secure = 1'b1;
                     end
                     FCSD_OP_ID, FCSD_OP_QUERY:
                     begin
                        next_s.table_sp = 1'b1;
                     end
                     default:
                     begin
                        next_s.table_sp = s.table_sp;
                     end
                  endcase
               end
            end
         end
         default:
         begin
            next_s.st = FCSD_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '{st: FCSD_IDLE, r: '{op: FCSD_OP_READ, enhanced: 1'b0,
                addr: '0, data: '0, count: 9'h000},
                step: 4'h0, slot: 9'h000, secure: 1'b0, table_sp: 1'b0,
                resp_valid: 1'b0, resp_data: '0};
      end
      else if (clk_en)
      begin
         s <= next_s;
      end
   end

   fcsd_bus_cycle u_cycle
   (
      .mclk(mclk),
      .nrst(nrst),
      .clk_en(clk_en),
      .start(bc_start),
      .is_read(cyc_read),
      .cyc(cyc),
      .dq_in(flash_dq_in),
      .pins(pins),
      .busy(bc_busy),
      .done(bc_done),
      .rd_data(bc_data)
   );

   assign req_ready = (s.st == FCSD_IDLE);
   assign resp_valid = s.resp_valid;
   assign resp_data = s.resp_data;
   assign in_secure = s.secure;
   assign in_table = s.table_sp;
   assign flash_ce_n = pins.ce_n;
   assign flash_we_n = pins.we_n;
   assign flash_oe_n = pins.oe_n;
   assign flash_addr = pins.addr;
   assign flash_dq_out = pins.dq_out;
   assign flash_dq_oe = pins.dq_oe;

   a_prog_third: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_PROG && s.step == 4'h2
      |-> cyc.addr == LOC_UNLOCK1 && cyc.data == CODE_PROG)
      else $error("word program third cycle wrong");
   a_stat_read: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_STAT_RD &&
      s.step == 4'h0 |-> cyc.data == CODE_STAT_RD && !cyc_read)
      else $error("status read command wrong");
   a_erase_last: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_CHIP_ERASE &&
      s.step == 4'h5 |-> cyc.data == CODE_CHIP && cyc.addr == LOC_UNLOCK1)
      else $error("chip erase final cycle wrong");
   a_sect_last: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_SECT_ERASE &&
      s.step == 4'h5 |-> cyc.data == CODE_SECTOR && cyc.addr == s.r.addr)
      else $error("sector erase final cycle wrong");
   a_erase_fourth: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_SECT_ERASE &&
      s.step == 4'h3 |-> cyc.data == CODE_UNLOCK1)
      else $error("erase second unlock wrong");
   a_reset_clears: assert property (@(posedge mclk)
      disable iff (!nrst) clk_en && s.st == FCSD_WAIT && bc_done &&
      s.r.op == FCSD_OP_RESET |=> !s.secure && !s.table_sp)
      else $error("reset did not leave alternate space");
   a_secure_exit: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_SECURE_EXIT &&
      s.step == 4'h3 |-> cyc.data == CODE_EXIT && cyc_last)
      else $error("secure exit final cycle wrong");
   a_buf_confirm: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_BUF &&
      s.step == 4'h5 |-> cyc.data == CODE_BUF_CONF && cyc.addr == s.r.addr)
      else $error("buffer confirm wrong");
   a_read_single: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start && s.r.op == FCSD_OP_READ
      |-> cyc_read && cyc_last)
      else $error("array read not a single read");
   a_issue_idle: assert property (@(posedge mclk)
      disable iff (!nrst) bc_start |-> !bc_busy)
      else $error("bus cycle started while one is running");
endmodule

// [bench/fcsd_flash_model.sv]
// Behavioural x16 flash: logs host write strobes and answers reads.
// Assumes the host drives its pins from registers clocked by mclk.
`timescale 1ns/1ns
module fcsd_flash_model
(
   input wire logic mclk,
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic [25:0] addr,
   input wire logic [15:0] dq,
   input wire logic dq_oe,
   output logic [15:0] dq_in
);
   import fcsd_pkg::*;
   fcsd_cyc_t log_q[$];
   logic we_q = 1'b1;
   logic oe_q = 1'b1;
   logic stat = 1'b0;
   logic tbl = 1'b0;
   logic sec = 1'b0;
   logic ex = 1'b0;
   int unl = 0;
   logic [15:0] last = 16'h0000;
   logic [15:0] rdv;
   always_comb
   begin
      if (tbl)
         rdv = {8'h77, addr[7:0]};
      else if (stat)
         rdv = 16'h0080;
      else
         rdv = addr[15:0] ^ 16'hA5A5;
   end
   // A released bus shows the inverse of the last word, never a held value.
   assign dq_in = (!ce_n && !oe_n) ? rdv : ~last;
   always @(posedge mclk)
   begin
      we_q <= we_n;
      oe_q <= oe_n;
      if (!ce_n && !oe_n)
         last <= rdv;
      if (oe_n && !oe_q)
         stat <= 1'b0;
      if (!ce_n && !we_n && we_q && dq_oe)
      begin
         log_q.push_back({addr, dq});
         if (dq == CODE_RESET)
         begin
            tbl <= 1'b0;
            sec <= 1'b0;
            unl <= 0;
         end
         else if (ex)
         begin
            sec <= (dq != CODE_EXIT);
            ex <= 1'b0;
         end
         else if (unl == 2 && addr[15:0] == 16'h0555)
         begin
            tbl <= tbl | (dq == CODE_ID && !sec);
            ex <= sec && dq == CODE_ID;
            sec <= sec | (dq == CODE_SECURE);
            unl <= 0;
         end
         else if (unl == 1 && dq == CODE_UNLOCK2 && addr == LOC_UNLOCK2)
            unl <= 2;
         else if (dq == CODE_UNLOCK1 && addr == LOC_UNLOCK1)
            unl <= 1;
         else
         begin
            unl <= 0;
            stat <= (dq == CODE_STAT_RD && addr == LOC_UNLOCK1);
            tbl <= tbl | (dq == CODE_QUERY &&
               addr[15:0] == 16'h0055);
         end
      end
   end
endmodule

// [bench/test_fcsd_host.sv]
// Self-checking bench for the flash command host against a flash model.
// Assumes the model logs every write strobe that the host makes.
`timescale 1ns/1ns
module test_fcsd_host;
   import fcsd_pkg::*;
   localparam logic [25:0] DC = 26'h3FFFFFF;
   localparam logic [25:0] U1 = 26'h0000555;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic req_valid = 1'b0;
   logic ce = 1'b1;
   fcsd_req_t req = '0;
   logic req_ready, buf_rd, resp_valid, in_secure, in_table;
   logic ce_n, we_n, oe_n, dq_oe;
   logic [8:0] buf_idx;
   logic [15:0] resp_data, rd, dq_out, dq_in;
   logic [25:0] fa;
   int n_fail = 0;
   int n_compared = 0;
   int st;
   fcsd_cyc_t exp_q[$];
   initial forever #25 mclk = ~mclk;
   fcsd_host u_fcsd_host
   (
      .mclk(mclk), .nrst(nrst), .clk_en(ce), .req_valid(req_valid),
      .req_ready(req_ready), .req(req), .buf_rd(buf_rd),
      .buf_idx(buf_idx),
      .buf_data(buf_rd ? (16'hC300 | {7'h00, buf_idx}) : 16'h0000),
      .resp_valid(resp_valid), .resp_data(resp_data),
      .in_secure(in_secure), .in_table(in_table), .flash_ce_n(ce_n),
      .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_addr(fa),
      .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in)
   );
   fcsd_flash_model u_fcsd_flash_model
   (
      .mclk(mclk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .addr(fa),
      .dq(dq_out), .dq_oe(dq_oe), .dq_in(dq_in)
   );
   task automatic complete_run();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic push(input logic [25:0] a, input logic [15:0] d);
      exp_q.push_back({a, d});
   endtask
   task automatic unl();
      push(U1, CODE_UNLOCK1);
      push(LOC_UNLOCK2, CODE_UNLOCK2);
   endtask
   task automatic do_op(input fcsd_op_t op, input logic enh,
      input logic [25:0] a, input logic [8:0] cnt);
      int i;
      st = u_fcsd_flash_model.log_q.size();
      @(posedge mclk);
      req_valid <= 1'b1;
      req <= '{op: op, enhanced: enh, addr: a, data: 16'h1357, count: cnt};
      i = 0;
      do
      begin
         @(negedge mclk);
         i++;
      end
      while (req_ready !== 1'b1 && i < 400);
      @(posedge mclk);
      req_valid <= 1'b0;
      do
      begin
         @(negedge mclk);
         i++;
      end
      while (resp_valid !== 1'b1 && i < 400);
      if (i >= 400)
      begin
         n_fail++;
         complete_run();
      end
      rd = resp_data;
      @(negedge mclk);
   endtask
   task automatic chk_seq();
      fcsd_cyc_t c;
      chk(u_fcsd_flash_model.log_q.size() - st, exp_q.size());
      foreach (exp_q[k])
      begin
         c = u_fcsd_flash_model.log_q[st + k];
         if (exp_q[k].addr !== DC)
            chk(c.addr, exp_q[k].addr);
         chk(c.data, exp_q[k].data);
      end
      exp_q.delete();
   endtask
   task automatic t_basic();
      do_op(FCSD_OP_READ, 1'b0, 26'h0001234, 9'h000);
      chk_seq();
      chk(rd, 16'h1234 ^ 16'hA5A5);
      push(U1, CODE_STAT_RD);
      do_op(FCSD_OP_STAT_RD, 1'b0, 26'h0000777, 9'h000);
      chk_seq();
      chk(rd, 16'h0080);
      push(U1, CODE_STAT_CLR);
      do_op(FCSD_OP_STAT_CLR, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
      unl();
      push(U1, CODE_PROG);
      push(26'h0123456, 16'h1357);
      do_op(FCSD_OP_PROG, 1'b0, 26'h0123456, 9'h000);
      chk_seq();
   endtask
   task automatic t_erase_susp();
      fcsd_op_t ops[4] = '{FCSD_OP_SUSPEND, FCSD_OP_SUSPEND,
         FCSD_OP_RESUME, FCSD_OP_RESUME};
      logic [15:0] codes[4] = '{CODE_SUSP, CODE_PSUSP,
         CODE_RESUME, CODE_PRESUME};
      for (int s = 0; s < 2; s++)
      begin
         unl();
         push(U1, CODE_ERASE);
         unl();
         push(s ? 26'h0230000 : U1, s ? CODE_SECTOR : CODE_CHIP);
         do_op(s ? FCSD_OP_SECT_ERASE : FCSD_OP_CHIP_ERASE, 1'b0,
            26'h0230000, 9'h000);
         chk_seq();
      end
      for (int k = 0; k < 4; k++)
      begin
         push(DC, codes[k]);
         do_op(ops[k], k[0], 26'h0000000, 9'h000);
         chk_seq();
      end
   endtask
   task automatic t_buffer();
      for (int n = 1; n <= 3; n += 2)
      begin
         unl();
         push(26'h0040010, CODE_BUF_LOAD);
         push(26'h0040010, 16'(n - 1));
         for (int i = 0; i < n; i++)
            push(26'h0040010 + 26'(i), 16'hC300 | 16'(i));
         push(26'h0040010, CODE_BUF_CONF);
         do_op(FCSD_OP_BUF, 1'b0, 26'h0040010, 9'(n));
         chk_seq();
      end
      unl();
      push(U1, CODE_RESET);
      do_op(FCSD_OP_BUF_ABORT, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
   endtask
   task automatic t_spaces();
      unl();
      push(26'h0050555, CODE_ID);
      do_op(FCSD_OP_ID, 1'b0, 26'h0050000, 9'h000);
      chk_seq();
      chk(in_table, 1'b1);
      do_op(FCSD_OP_READ, 1'b0, 26'h0000012, 9'h000);
      chk(rd, 16'h7712);
      push(DC, CODE_RESET);
      do_op(FCSD_OP_RESET, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
      chk(in_table, 1'b0);
      push(26'h0060055, CODE_QUERY);
      do_op(FCSD_OP_QUERY, 1'b0, 26'h0060000, 9'h000);
      chk_seq();
      do_op(FCSD_OP_READ, 1'b0, 26'h0000031, 9'h000);
      chk(rd, 16'h7731);
      do_op(FCSD_OP_RESET, 1'b0, 26'h0000000, 9'h000);
      do_op(FCSD_OP_READ, 1'b0, 26'h0000031, 9'h000);
      chk(rd, 16'h0031 ^ 16'hA5A5);
      unl();
      push(U1, CODE_SECURE);
      do_op(FCSD_OP_SECURE, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
      chk(in_secure, 1'b1);
      unl();
      push(U1, CODE_ID);
      push(DC, CODE_EXIT);
      do_op(FCSD_OP_SECURE_EXIT, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
      chk(in_secure, 1'b0);
      unl();
      push(U1, CODE_LOCK);
      do_op(FCSD_OP_LOCK, 1'b0, 26'h0000000, 9'h000);
      chk_seq();
   endtask
   // Drops the clock enable in mid-strobe; the strobe must stay frozen.
   task automatic t_freeze();
      int i;
      push(U1, CODE_STAT_CLR);
      fork
         do_op(FCSD_OP_STAT_CLR, 1'b0, 26'h0000000, 9'h000);
         begin
            i = 0;
            while (we_n !== 1'b0 && i < 50)
            begin
               @(negedge mclk);
               i++;
            end
            @(posedge mclk);
            ce <= 1'b0;
            repeat (10) @(posedge mclk);
            @(negedge mclk);
            chk(we_n, 1'b0);
            @(posedge mclk);
            ce <= 1'b1;
         end
      join
      chk_seq();
   endtask
   initial
   begin
      repeat (4) @(posedge mclk);
      nrst <= 1'b1;
      t_basic();
      t_erase_susp();
      t_buffer();
      t_spaces();
      t_freeze();
      complete_run();
   end
endmodule
